// >>> inc/hss_pkg.sv
// Shared constants and types for the CRT/TV horizontal sync start block.
// Assumes a single pixel clock and an 8-bit register port.
package hss_pkg;

    // Widths
    localparam int unsigned HSS_ADDR_W  = 8;
    localparam int unsigned HSS_DATA_W  = 8;
    localparam int unsigned HSS_POS_W   = 6;
    localparam int unsigned HSS_DISP_W  = 7;
    localparam int unsigned HSS_ND_W    = 6;
    localparam int unsigned HSS_SYNC_W  = 4;
    localparam int unsigned HSS_OFS_W   = 10;
    localparam int unsigned HSS_CNT_W   = 11;
    localparam int unsigned HSS_UNIT_SH = 3;

    // Register offsets
    localparam logic [7:0] HSS_DISP_WIDTH_OFS  = 8'h00;
    localparam logic [7:0] HSS_NONDISP_OFS     = 8'h01;
    localparam logic [7:0] HSS_SYNC_START_OFS  = 8'h02;
    localparam logic [7:0] HSS_SYNC_WIDTH_OFS  = 8'h03;
    localparam logic [7:0] HSS_MODE_OFS        = 8'h04;
    localparam logic [7:0] HSS_STATUS_OFS      = 8'h05;

    // Mode register field positions
    localparam int unsigned HSS_MODE_EN_BIT    = 0;
    localparam int unsigned HSS_MODE_TYPE_LSB  = 1;
    localparam int unsigned HSS_MODE_BPP16_BIT = 3;

    // Values after reset
    localparam logic [6:0] HSS_DISP_WIDTH_RST = 7'h4f;
    localparam logic [5:0] HSS_NONDISP_RST    = 6'h13;
    localparam logic [5:0] HSS_SYNC_START_RST = 6'h02;
    localparam logic [3:0] HSS_SYNC_WIDTH_RST = 4'h3;
    localparam logic [7:0] HSS_MODE_RST       = 8'h00;

    // Pixel arithmetic
    localparam logic [9:0]  HSS_UNIT_PX    = 10'h008;
    localparam logic [9:0]  HSS_CRT8_ADD   = 10'h004;
    localparam logic [9:0]  HSS_CRT16_ADD  = 10'h005;
    localparam logic [9:0]  HSS_TV8_SUB    = 10'h007;
    localparam logic [9:0]  HSS_TV16_SUB   = 10'h005;
    localparam logic [10:0] HSS_NTSC_ND_ADD = 11'h006;
    localparam logic [10:0] HSS_PAL_ND_ADD  = 11'h007;

    typedef enum logic [1:0] {
        HSS_OUT_CRT,
        HSS_OUT_NTSC,
        HSS_OUT_PAL
    } hss_out_e;

    typedef struct packed {
        logic [HSS_ADDR_W-1:0] addr;
        logic [HSS_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } hss_bus_s;

    typedef struct packed {
        logic [HSS_DISP_W-1:0] disp_w;
        logic [HSS_ND_W-1:0]   nd_w;
        logic [HSS_POS_W-1:0]  start_pos;
        logic [HSS_SYNC_W-1:0] sync_w;
        hss_out_e              out_type;
        logic                  bpp16;
        logic                  enable;
    } hss_cfg_s;

endpackage

// >>> src/hss_line_timer.sv
// Horizontal line timer: display phase, then non-display phase.
// Assumes the pixel clock and a synchronised active-low reset.
`timescale 1ns/10ps
module hss_line_timer (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [hss_pkg::HSS_DISP_W-1:0] disp_w,
    input  wire logic [hss_pkg::HSS_ND_W-1:0]   nd_w,
    input  wire hss_pkg::hss_out_e              out_type,
    output logic                               in_nd,
    output logic [hss_pkg::HSS_CNT_W-1:0]       cnt
);
    typedef enum logic {HSS_PH_DISP, HSS_PH_ND} hss_phase_e;

    hss_phase_e                    phase_q;
    logic [hss_pkg::HSS_CNT_W-1:0] cnt_q;
    logic [hss_pkg::HSS_CNT_W-1:0] disp_len;
    logic [hss_pkg::HSS_CNT_W-1:0] nd_len;
    logic [hss_pkg::HSS_CNT_W-1:0] nd_base;
    logic [hss_pkg::HSS_CNT_W-1:0] cur_len;

    // Phase lengths in pixels
    assign disp_len = {1'b0, disp_w, 3'h0} + 11'h008;
    assign nd_base  = {2'h0, nd_w, 3'h0};
    always_comb begin
        case (out_type)
            hss_pkg::HSS_OUT_NTSC: nd_len = nd_base + hss_pkg::HSS_NTSC_ND_ADD;
            hss_pkg::HSS_OUT_PAL:  nd_len = nd_base + hss_pkg::HSS_PAL_ND_ADD;
            default:               nd_len = nd_base + 11'h008;
        endcase
    end
    assign cur_len = (phase_q == HSS_PH_ND) ? nd_len : disp_len;

    // Count pixels; >= keeps a shrunk length from running the counter away
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= HSS_PH_DISP;
            cnt_q   <= '0;
        end else if (cnt_q >= cur_len - 11'h001) begin
            phase_q <= (phase_q == HSS_PH_ND) ? HSS_PH_DISP : HSS_PH_ND;
            cnt_q   <= '0;
        end else begin
            cnt_q   <= cnt_q + 11'h001;
        end
    end

    assign in_nd = (phase_q == HSS_PH_ND);
    assign cnt   = cnt_q;
endmodule

// >>> src/hss_start_calc.sv
// Converts the programmed sync start field into a pixel offset.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/10ps
module hss_start_calc (
    input  wire logic [hss_pkg::HSS_POS_W-1:0] start_pos,
    input  wire hss_pkg::hss_out_e             out_type,
    input  wire logic                          bpp16,
    output logic [hss_pkg::HSS_OFS_W-1:0]      start_px
);
    localparam int unsigned PAD = hss_pkg::HSS_OFS_W - hss_pkg::HSS_POS_W
                                  - hss_pkg::HSS_UNIT_SH;

    logic [hss_pkg::HSS_OFS_W-1:0] base_px;
    logic [hss_pkg::HSS_OFS_W-1:0] next_px;

    // Field in 8-pixel units, and one unit further for the TV forms
    assign base_px = {{PAD{1'b0}}, start_pos, {hss_pkg::HSS_UNIT_SH{1'b0}}};
    assign next_px = base_px + hss_pkg::HSS_UNIT_PX;

    // Offset per output type and colour depth
    always_comb begin
        case (out_type)
            hss_pkg::HSS_OUT_NTSC: begin
                start_px = bpp16 ? next_px - hss_pkg::HSS_TV16_SUB
                                 : next_px - hss_pkg::HSS_TV8_SUB;
            end
            // No 16 bpp figure exists for PAL; the 4/8 bpp form is reused
            hss_pkg::HSS_OUT_PAL: begin
                start_px = next_px - hss_pkg::HSS_TV8_SUB;
            end
            hss_pkg::HSS_OUT_CRT: begin
                start_px = bpp16 ? base_px + hss_pkg::HSS_CRT16_ADD
                                 : base_px + hss_pkg::HSS_CRT8_ADD;
            end
            default: begin
                start_px = base_px + hss_pkg::HSS_CRT8_ADD;
            end
        endcase
    end
endmodule

// >>> src/hss_sync_top.sv
// CRT/TV horizontal sync start: register port, line timer and sync pulse.
// Assumes core_clk is the CRT/TV pixel clock and that the register master
// follows one-cycle strobes with read data the cycle after.
`timescale 1ns/10ps
module hss_sync_top (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic [hss_pkg::HSS_ADDR_W-1:0] reg_addr,
    input  wire logic [hss_pkg::HSS_DATA_W-1:0] reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [hss_pkg::HSS_DATA_W-1:0]      reg_rdata,
    output logic                               horizontal_sync_pulse,
    output logic                               line_blank
);
    logic                          rst_meta_q;
    logic                          rst_sync_q;
    hss_pkg::hss_bus_s             bus;
    hss_pkg::hss_cfg_s             cfg;
    logic [hss_pkg::HSS_DISP_W-1:0] disp_w_q;
    logic [hss_pkg::HSS_ND_W-1:0]  nd_w_q;
    logic [hss_pkg::HSS_POS_W-1:0] start_pos_q;
    logic [hss_pkg::HSS_SYNC_W-1:0] sync_w_q;
    logic [hss_pkg::HSS_DATA_W-1:0] mode_q;
    logic [hss_pkg::HSS_DATA_W-1:0] rdata_q;
    logic [hss_pkg::HSS_DATA_W-1:0] rdata_d;
    logic [hss_pkg::HSS_OFS_W-1:0] start_px;
    logic                          in_nd;
    logic [hss_pkg::HSS_CNT_W-1:0] nd_cnt;
    logic                          start_hit;
    logic                          sync_q;
    logic                          blank_q;
    logic [6:0]                    wcnt_q;
    logic [6:0]                    wlen;
    logic                          sync_end;

    // Reset release through two flops; assertion is still immediate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Bundle the register port
    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;

    // Display width register
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            disp_w_q <= hss_pkg::HSS_DISP_WIDTH_RST;
        end else if (bus.wr && bus.addr == hss_pkg::HSS_DISP_WIDTH_OFS) begin
            disp_w_q <= bus.wdata[hss_pkg::HSS_DISP_W-1:0];
        end
    end

    // Non-display period register
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            nd_w_q <= hss_pkg::HSS_NONDISP_RST;
        end else if (bus.wr && bus.addr == hss_pkg::HSS_NONDISP_OFS) begin
            nd_w_q <= bus.wdata[hss_pkg::HSS_ND_W-1:0];
        end
    end

    // Sync start position, six bits in 8-pixel units
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            start_pos_q <= hss_pkg::HSS_SYNC_START_RST;
        end else if (bus.wr && bus.addr == hss_pkg::HSS_SYNC_START_OFS) begin
            start_pos_q <= bus.wdata[hss_pkg::HSS_POS_W-1:0];
        end
    end

    // Sync width register
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sync_w_q <= hss_pkg::HSS_SYNC_WIDTH_RST;
        end else if (bus.wr && bus.addr == hss_pkg::HSS_SYNC_WIDTH_OFS) begin
            sync_w_q <= bus.wdata[hss_pkg::HSS_SYNC_W-1:0];
        end
    end

    // Mode register: enable, output type, colour depth
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            mode_q <= hss_pkg::HSS_MODE_RST;
        end else if (bus.wr && bus.addr == hss_pkg::HSS_MODE_OFS) begin
            mode_q <= {4'h0, bus.wdata[3:0]};
        end
    end

    // Decoded configuration; type code 3 falls back to CRT
    assign cfg.disp_w    = disp_w_q;
    assign cfg.nd_w      = nd_w_q;
    assign cfg.start_pos = start_pos_q;
    assign cfg.sync_w    = sync_w_q;
    assign cfg.enable    = mode_q[hss_pkg::HSS_MODE_EN_BIT];
    assign cfg.bpp16     = mode_q[hss_pkg::HSS_MODE_BPP16_BIT];
    always_comb begin
        case (mode_q[hss_pkg::HSS_MODE_TYPE_LSB +: 2])
            2'h1:    cfg.out_type = hss_pkg::HSS_OUT_NTSC;
            2'h2:    cfg.out_type = hss_pkg::HSS_OUT_PAL;
            default: cfg.out_type = hss_pkg::HSS_OUT_CRT;
        endcase
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (bus.addr)
            hss_pkg::HSS_DISP_WIDTH_OFS: rdata_d = {1'b0, disp_w_q};
            hss_pkg::HSS_NONDISP_OFS:    rdata_d = {2'h0, nd_w_q};
            hss_pkg::HSS_SYNC_START_OFS: rdata_d = {2'h0, start_pos_q};
            hss_pkg::HSS_SYNC_WIDTH_OFS: rdata_d = {4'h0, sync_w_q};
            hss_pkg::HSS_MODE_OFS:       rdata_d = mode_q;
            hss_pkg::HSS_STATUS_OFS:     rdata_d = {6'h00, in_nd, sync_q};
            default:                     rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    hss_start_calc u_calc (
        .start_pos (cfg.start_pos),
        .out_type  (cfg.out_type),
        .bpp16     (cfg.bpp16),
        .start_px  (start_px)
    );

    hss_line_timer u_timer (
        .clk      (core_clk),
        .rst_n    (rst_sync_q),
        .disp_w   (cfg.disp_w),
        .nd_w     (cfg.nd_w),
        .out_type (cfg.out_type),
        .in_nd    (in_nd),
        .cnt      (nd_cnt)
    );

    // Match of the non-display pixel count against the computed offset
    assign start_hit = cfg.enable && in_nd
                       && nd_cnt == {1'b0, start_px};
    assign wlen      = {cfg.sync_w, 3'h0} + 7'h07;
    // The pulse never spills into the next display phase
    assign sync_end  = (wcnt_q >= wlen) || !in_nd;

    // Sync pulse: leading edge one pixel after the match, width in 8-pixel units
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sync_q <= 1'b0;
            wcnt_q <= '0;
        end else if (start_hit) begin
            sync_q <= 1'b1;
            wcnt_q <= '0;
        end else if (sync_q && sync_end) begin
            sync_q <= 1'b0;
            wcnt_q <= '0;
        end else if (sync_q) begin
            wcnt_q <= wcnt_q + 7'h01;
        end
    end

    // Blanking follows the non-display phase, delayed to line up with sync
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            blank_q <= 1'b0;
        end else begin
            blank_q <= in_nd;
        end
    end

    assign reg_rdata             = rdata_q;
    assign horizontal_sync_pulse = sync_q;
    assign line_blank            = blank_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_q);

    a_start_field_write: assert property (
        bus.wr && bus.addr == hss_pkg::HSS_SYNC_START_OFS
        |=> {2'h0, start_pos_q} == ($past(bus.wdata) & 8'h3f))
        else $error("start field not stored");

    // Mode is taken from the match cycle; a mode write can land on the rise
    a_crt8_edge: assert property (
        $rose(sync_q) && $past(cfg.out_type) == hss_pkg::HSS_OUT_CRT
        && !$past(cfg.bpp16)
        |-> $past(nd_cnt) == {2'h0, $past(start_pos_q), 3'h0} + 11'h004)
        else $error("CRT 4/8 bpp sync edge misplaced");

    a_crt16_edge: assert property (
        $rose(sync_q) && $past(cfg.out_type) == hss_pkg::HSS_OUT_CRT
        && $past(cfg.bpp16)
        |-> $past(nd_cnt) == {2'h0, $past(start_pos_q), 3'h0} + 11'h005)
        else $error("CRT 16 bpp sync edge misplaced");

    a_ntsc8_edge: assert property (
        $rose(sync_q) && $past(cfg.out_type) == hss_pkg::HSS_OUT_NTSC
        && !$past(cfg.bpp16)
        |-> $past(nd_cnt) == {2'h0, $past(start_pos_q), 3'h0} + 11'h008 - 11'h007)
        else $error("NTSC 4/8 bpp sync edge misplaced");

    a_ntsc16_edge: assert property (
        $rose(sync_q) && $past(cfg.out_type) == hss_pkg::HSS_OUT_NTSC
        && $past(cfg.bpp16)
        |-> $past(nd_cnt) == {2'h0, $past(start_pos_q), 3'h0} + 11'h008 - 11'h005)
        else $error("NTSC 16 bpp sync edge misplaced");

    a_pal8_edge: assert property (
        $rose(sync_q) && $past(cfg.out_type) == hss_pkg::HSS_OUT_PAL
        && !$past(cfg.bpp16)
        |-> $past(nd_cnt) == {2'h0, $past(start_pos_q), 3'h0} + 11'h008 - 11'h007)
        else $error("PAL 4/8 bpp sync edge misplaced");

    a_match_starts_sync: assert property (
        start_hit |=> sync_q ##0 $past(in_nd))
        else $error("sync did not start on count match");

    a_rise_needs_match: assert property (
        $rose(sync_q) |-> $past(cfg.enable) && $past(in_nd))
        else $error("sync rose outside non-display or when disabled");

    a_read_one_cycle: assert property (
        !bus.rd |=> rdata_q == 8'h00)
        else $error("read data held beyond one cycle");

    // Read data must mirror the register sampled with the strobe
    a_start_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_SYNC_START_OFS
        |=> rdata_q == {2'h0, $past(start_pos_q)})
        else $error("start field read back wrong");

    a_disp_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_DISP_WIDTH_OFS
        |=> rdata_q == {1'b0, $past(disp_w_q)})
        else $error("display width read back wrong");

    a_nd_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_NONDISP_OFS
        |=> rdata_q == {2'h0, $past(nd_w_q)})
        else $error("non-display width read back wrong");

    a_width_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_SYNC_WIDTH_OFS
        |=> rdata_q == {4'h0, $past(sync_w_q)})
        else $error("sync width read back wrong");

    a_mode_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_MODE_OFS
        |=> rdata_q == $past(mode_q))
        else $error("mode read back wrong");

    a_status_readback: assert property (
        bus.rd && bus.addr == hss_pkg::HSS_STATUS_OFS
        |=> rdata_q == {6'h00, $past(in_nd), $past(sync_q)})
        else $error("status read back wrong");

    a_unmapped_zero: assert property (
        bus.rd && bus.addr > hss_pkg::HSS_STATUS_OFS
        |=> rdata_q == 8'h00)
        else $error("unmapped read not zero");

    // Pulse shape: never outside blanking, never cut short unless non-display ends, no pulse starts when off
    a_sync_in_blank: assert property (
        sync_q |-> blank_q)
        else $error("sync high outside blanking");

    a_pulse_end: assert property (
        $fell(sync_q) |-> $past(wcnt_q) >= $past(wlen) || !$past(in_nd))
        else $error("sync pulse ended early");

    a_off_stays_quiet: assert property (
        !cfg.enable && !sync_q |=> !sync_q)
        else $error("sync started while disabled");

    // Main scenarios
    c_crt_sync:  cover property ($rose(sync_q) && cfg.out_type == hss_pkg::HSS_OUT_CRT);
    c_ntsc_sync: cover property ($rose(sync_q) && cfg.out_type == hss_pkg::HSS_OUT_NTSC);
    c_pal_sync:  cover property ($rose(sync_q) && cfg.out_type == hss_pkg::HSS_OUT_PAL);
    c_sync_full: cover property ($fell(sync_q) && in_nd);
    c_deep_sync: cover property ($rose(sync_q) && cfg.bpp16);
endmodule

// >>> tb/hss_crt_monitor.sv
// Far-side model: a CRT monitor or TV encoder watching blank and sync.
// Assumes both inputs are registered outputs of the sync block.
`timescale 1ns/10ps
module hss_crt_monitor (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        line_blank,
    input  wire logic        horizontal_sync_pulse,
    output logic             line_done,
    output logic             seen,
    output logic [10:0]      meas,
    output logic [10:0]      width
);
    logic        blank_q;
    logic        sync_q;
    logic        seen_q;
    logic [10:0] cnt_q;
    logic [10:0] wcnt_q;

    // Cycles from blank rise to sync rise, and sync width, per line
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_q   <= 1'b0;
            sync_q    <= 1'b0;
            seen_q    <= 1'b0;
            cnt_q     <= 11'h000;
            wcnt_q    <= 11'h000;
            line_done <= 1'b0;
            seen      <= 1'b0;
            meas      <= 11'h000;
            width     <= 11'h000;
        end else begin
            blank_q   <= line_blank;
            sync_q    <= horizontal_sync_pulse;
            line_done <= blank_q && !line_blank;
            cnt_q     <= (line_blank && !blank_q) ? 11'h001 : cnt_q + 11'h001;
            wcnt_q    <= (horizontal_sync_pulse && !sync_q) ? 11'h001 : wcnt_q + 11'h001;
            if (line_blank && !blank_q) begin
                seen_q <= 1'b0;
            end
            // A sync seen while blanking belongs to this line
            if (horizontal_sync_pulse && !sync_q) begin
                meas   <= cnt_q;
                seen_q <= 1'b1;
            end
            if (!horizontal_sync_pulse && sync_q) begin
                width <= wcnt_q;
            end
            if (blank_q && !line_blank) begin
                seen <= seen_q;
            end
        end
    end
endmodule

// >>> tb/tb_hss_sync_top.sv
// Self-checking bench for the horizontal sync start block.
// Assumes the register map and offsets given in the design hand-over.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_hss_sync_top;
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        horizontal_sync_pulse;
    logic        line_blank;
    logic        line_done;
    logic        seen;
    logic [10:0] meas;
    logic [10:0] width;
    int          num_errors;
    int          checks;

    hss_sync_top uut (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .horizontal_sync_pulse (horizontal_sync_pulse),
        .line_blank            (line_blank)
    );

    hss_crt_monitor mon (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .line_blank            (line_blank),
        .horizontal_sync_pulse (horizontal_sync_pulse),
        .line_done             (line_done),
        .seen                  (seen),
        .meas                  (meas),
        .width                 (width)
    );

    // 250 MHz pixel clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data sampled in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Bounded wait for the end of one blanking interval
    task automatic wait_line();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (line_done !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            `CHK(1'b0, 1'b1)
        end
    endtask

    // Settle two lines after a change, then judge a third
    task automatic run_mode(input logic [7:0] mode, input logic [5:0] p, input bit pulse,
                            input logic [10:0] exp_ofs);
        wr(hss_pkg::HSS_SYNC_START_OFS, {2'b00, p});
        wr(hss_pkg::HSS_MODE_OFS, mode);
        wait_line();
        wait_line();
        wait_line();
        `CHK(seen, pulse)
        if (pulse) begin
            `CHK(meas, exp_ofs)
            if (p == 6'h00) begin
                `CHK(width, 11'h020)
            end
        end
        $display("test mode=%h pos=%h done", mode, p);
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        logic [7:0]  d;
        logic [7:0]  modes [5];
        logic [10:0] p11;
        num_errors = 0;
        checks     = 0;
        rst_n      = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        // CRT 4/8, CRT 16, NTSC 4/8, NTSC 16, PAL 4/8; all enabled
        modes = '{8'h01, 8'h09, 8'h03, 8'h0b, 8'h05};
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);

        // Reset values and disabled output
        rd(hss_pkg::HSS_SYNC_START_OFS, d);
        `CHK(d, 8'h02)
        rd(hss_pkg::HSS_MODE_OFS, d);
        `CHK(d, 8'h00)
        wait_line();
        wait_line();
        `CHK(seen, 1'b0)
        $display("test reset done");

        // Field is six bits wide; unmapped place reads zero
        wr(hss_pkg::HSS_SYNC_START_OFS, 8'hff);
        rd(hss_pkg::HSS_SYNC_START_OFS, d);
        `CHK(d, 8'h3f)
        rd(8'h07, d);
        `CHK(d, 8'h00)
        $display("test field done");

        // Short display, longest blanking so every offset fits
        wr(hss_pkg::HSS_DISP_WIDTH_OFS, 8'h00);
        wr(hss_pkg::HSS_NONDISP_OFS, 8'h3f);
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 2; k++) begin
                p11 = (k == 0) ? 11'h000 : 11'h03f;
                case (i)
                    0: run_mode(modes[i], p11[5:0], 1'b1, p11 * 8 + 4);
                    1: run_mode(modes[i], p11[5:0], 1'b1, p11 * 8 + 5);
                    2: run_mode(modes[i], p11[5:0], 1'b1, (p11 + 1) * 8 - 7);
                    3: run_mode(modes[i], p11[5:0], 1'b1, (p11 + 1) * 8 - 5);
                    default: run_mode(modes[i], p11[5:0], 1'b1, (p11 + 1) * 8 - 7);
                endcase
            end
        end

        // Offset past the end of blanking gives no pulse
        wr(hss_pkg::HSS_NONDISP_OFS, 8'h13);
        // Type code 3 falls back to CRT 4/8 bpp
        run_mode(8'h07, 6'h00, 1'b1, 11'h004);
        run_mode(8'h01, 6'h3f, 1'b0, 11'h000);
        // Disabled again after running
        run_mode(8'h00, 6'h00, 1'b0, 11'h000);
        give_verdict();
    end
endmodule
